// file: core/ast_defines.svh
// Register indices, field positions, reset values and timing counts of the serial transmitter
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH

// Register indices; byte address is four times the index
`define AST_IDX_IRQ_FLAGS_B 6'h10
`define AST_IDX_IRQ_ENABLES_B 6'h11
`define AST_IDX_RX_CTRL_STATUS 6'h13
`define AST_IDX_TX_CTRL_STATUS 6'h15
`define AST_IDX_TX_HOLDING_BUF 6'h16
`define AST_IDX_BAUD_DIVISOR 6'h17
`define AST_IDX_IRQ_FLAGS_A 6'h18
`define AST_IDX_IRQ_ENABLES_A 6'h19

// Field positions in the transmit control/status register
`define AST_TXCS_CLK_SRC 7
`define AST_TXCS_NINTH_EN 6
`define AST_TXCS_TX_EN 5
`define AST_TXCS_CLOCKED 4
`define AST_TXCS_SHIFTER_EMPTY 1
`define AST_TXCS_NINTH_VALUE 0

// Field positions elsewhere
`define AST_RXCS_PORT_EN 7
`define AST_IRQ_TX_BIT 1

// Reset values
`define AST_RST_TX_CTRL 8'h02
`define AST_RST_RX_CTRL 8'h00
`define AST_RST_BAUD_DIV 8'h00
`define AST_RST_IRQ_EN 8'h00

// Timing: generator ticks per bit, bits per frame
`define AST_TICKS_PER_BIT 64
`define AST_FRAME_BITS_8 4'd10
`define AST_FRAME_BITS_9 4'd11

`endif

// file: core/ast_pkg.sv
// Types shared by the serial transmitter
package ast_pkg;

  // Transmit sequencer states, one-hot
  typedef enum logic [2:0] {
    AST_IDLE  = 3'b001,
    AST_ARMED = 3'b010,
    AST_SHIFT = 3'b100
  } ast_state_t;

endpackage : ast_pkg

// file: core/ast_serial_tx.sv
// Asynchronous serial transmitter with baud generator and Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "ast_defines.svh"

// What this block does
// RULE1: Frames are one low start bit, eight or nine data bits, one high stop bit.
// RULE2: An eight-bit baud generator divides the clock by the divisor register value plus one.
// RULE3: Each transmitted bit lasts 64 baud generator ticks.
// RULE4: Transmit logic runs alone; frame format and baud setting are shared settings.
// RULE5: No parity logic; software supplies any parity through the ninth bit.
// RULE6: All activity freezes while the sleep input is high; the code freezes only the baud generator and sequencer, not the bus.
// RULE7: Asynchronous operation only while the clocked-mode select bit four is clear.
// RULE8: Shifter loads only when idle or as the stop bit ends, and only if the buffer is full.
// RULE9: Buffer-to-shifter move happens at a generator tick and sets the empty flag.
// RULE10: Empty flag ignores the enable, cannot be cleared by software, cleared by buffer write.
// RULE11: Interrupt request comes from the empty flag only while its enable is set.
// RULE12: Status bit one is read-only and reads one when the shifter is empty.
// RULE13: The shifter-empty status drives no interrupt.
// RULE14: The shift register cannot be read or written by software.
// RULE15: Bit five enables; a frame waits for buffered data and a shift clock.
// RULE16: Writing the buffer first and enabling afterwards also starts a frame.
// RULE17: Write to an empty shifter moves straight through, allowing back-to-back frames.
// RULE18: Clearing the enable aborts the frame and releases the pin.
// RULE19: Bit six selects nine-bit frames; the ninth bit comes from bit zero.
// RULE20: Software writes the ninth bit before the data byte.
// RULE21: Software programs divisor, mode, options, data, then enable, in that order.
// RULE22: Generator divides by divisor plus one.
// RULE23: Data goes least significant bit first; line idles high.
module ast_serial_tx (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleepMode,
  output logic txLinePinOut,
  output logic txLinePinOen,
  output logic txIrq
);

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------

  // True when the word address selects the given register index
  function automatic logic regHit(input logic [7:0] adr, input logic [5:0] idx);
    regHit = (adr[7:2] == idx);
  endfunction : regHit

  logic ack_q;
  logic [31:0] rdData_q;
  logic busAccess;
  logic busWrite;
  logic [7:0] txCtrl_q;
  logic portEnable_q;
  logic [7:0] baudDivisor_q;
  logic [7:0] holdBuf_q;
  logic bufFull_q;
  logic [7:0] irqEnablesA_q;
  logic [7:0] irqEnablesB_q;
  logic [7:0] baudCnt_q;
  logic [5:0] subCnt_q;
  logic [10:0] shiftReg_q;
  logic [3:0] bitsLeft_q;
  ast_pkg::ast_state_t state_q;
  logic baudTick;
  logic bitTick;
  logic txActive;
  logic loadNow;
  logic shifterEmpty;
  logic bufEmptyFlag;
  logic holdWrite;
  logic [10:0] frameWord;
  logic [3:0] frameBits;

  // Bus request taken on the edge where ack rises
  assign busAccess = wb_cyc_i && wb_stb_i && !ack_q;
  assign busWrite = busAccess && wb_we_i && wb_sel_i[0];
  assign holdWrite = busWrite && regHit(wb_adr_i, `AST_IDX_TX_HOLDING_BUF);

  // Status decoded from the sequencer and the buffer flag; transmit enable from the control bits
  assign shifterEmpty = (state_q == ast_pkg::AST_IDLE); // RULE12
  assign bufEmptyFlag = !bufFull_q; // RULE10
  assign txActive = portEnable_q && txCtrl_q[`AST_TXCS_TX_EN]
    && !txCtrl_q[`AST_TXCS_CLOCKED]; // RULE7 RULE15

  // Interrupt request from the buffer flag only; shifter status is poll-only
  assign txIrq = bufEmptyFlag && irqEnablesA_q[`AST_IRQ_TX_BIT]; // RULE11 RULE13

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------

  // Acknowledge one cycle after the request, drop it the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= busAccess;
    end
  end

  // Read data captured with the acknowledge; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_q <= 32'h0000_0000;
    end else if (busAccess) begin
      rdData_q <= 32'h0000_0000;
      if (regHit(wb_adr_i, `AST_IDX_TX_CTRL_STATUS)) begin
        rdData_q[7:0] <= {txCtrl_q[7:2], shifterEmpty, txCtrl_q[0]}; // RULE12
      end else if (regHit(wb_adr_i, `AST_IDX_RX_CTRL_STATUS)) begin
        rdData_q[`AST_RXCS_PORT_EN] <= portEnable_q;
      end else if (regHit(wb_adr_i, `AST_IDX_TX_HOLDING_BUF)) begin
        rdData_q[7:0] <= holdBuf_q; // RULE14
      end else if (regHit(wb_adr_i, `AST_IDX_BAUD_DIVISOR)) begin
        rdData_q[7:0] <= baudDivisor_q;
      end else if (regHit(wb_adr_i, `AST_IDX_IRQ_FLAGS_A)) begin
        rdData_q[`AST_IRQ_TX_BIT] <= bufEmptyFlag;
      end else if (regHit(wb_adr_i, `AST_IDX_IRQ_ENABLES_A)) begin
        rdData_q[7:0] <= irqEnablesA_q;
      end else if (regHit(wb_adr_i, `AST_IDX_IRQ_FLAGS_B)) begin
        rdData_q[7:0] <= 8'h00;
      end else if (regHit(wb_adr_i, `AST_IDX_IRQ_ENABLES_B)) begin
        rdData_q[7:0] <= irqEnablesB_q;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdData_q;

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------

  // Transmit control/status; bit one is never stored, bits three and two read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      txCtrl_q <= `AST_RST_TX_CTRL;
    end else if (busWrite && regHit(wb_adr_i, `AST_IDX_TX_CTRL_STATUS)) begin
      txCtrl_q <= {wb_dat_i[7:4], 2'b00, 1'b1, wb_dat_i[0]}; // RULE12
    end
  end

  // Port enable, the only receive control bit this block uses
  always_ff @(posedge clk) begin
    if (rst) begin
      portEnable_q <= 1'(`AST_RST_RX_CTRL >> `AST_RXCS_PORT_EN);
    end else if (busWrite && regHit(wb_adr_i, `AST_IDX_RX_CTRL_STATUS)) begin
      portEnable_q <= wb_dat_i[`AST_RXCS_PORT_EN];
    end
  end

  // Baud divisor, shared with the receive side
  always_ff @(posedge clk) begin
    if (rst) begin
      baudDivisor_q <= `AST_RST_BAUD_DIV;
    end else if (busWrite && regHit(wb_adr_i, `AST_IDX_BAUD_DIVISOR)) begin
      baudDivisor_q <= wb_dat_i[7:0]; // RULE2 RULE4
    end
  end

  // Interrupt enable registers
  always_ff @(posedge clk) begin
    if (rst) begin
      irqEnablesA_q <= `AST_RST_IRQ_EN;
      irqEnablesB_q <= `AST_RST_IRQ_EN;
    end else begin
      if (busWrite && regHit(wb_adr_i, `AST_IDX_IRQ_ENABLES_A)) begin
        irqEnablesA_q <= wb_dat_i[7:0];
      end
      if (busWrite && regHit(wb_adr_i, `AST_IDX_IRQ_ENABLES_B)) begin
        irqEnablesB_q <= wb_dat_i[7:0];
      end
    end
  end

  // Holding buffer data
  always_ff @(posedge clk) begin
    if (rst) begin
      holdBuf_q <= 8'h00;
    end else if (holdWrite) begin
      holdBuf_q <= wb_dat_i[7:0];
    end
  end

  // Buffer full; a write in the same cycle as a transfer leaves it full
  always_ff @(posedge clk) begin
    if (rst) begin
      bufFull_q <= 1'b0;
    end else if (holdWrite) begin
      bufFull_q <= 1'b1; // RULE10
    end else if (loadNow) begin
      bufFull_q <= 1'b0; // RULE9
    end
  end

  // ---------------------------------------------------------------
  // Baud generator
  // ---------------------------------------------------------------

  // Tick every divisor plus one cycles; frozen in sleep
  assign baudTick = !sleepMode && (baudCnt_q == 8'h00); // RULE22 RULE6
  assign bitTick = baudTick && (subCnt_q == 6'(`AST_TICKS_PER_BIT - 1)); // RULE3

  always_ff @(posedge clk) begin
    if (rst) begin
      baudCnt_q <= 8'h00;
    end else if (!sleepMode) begin
      if (baudCnt_q == 8'h00) begin
        baudCnt_q <= baudDivisor_q; // RULE2 RULE22
      end else begin
        baudCnt_q <= baudCnt_q - 8'h01;
      end
    end
  end

  // Ticks within one bit time
  always_ff @(posedge clk) begin
    if (rst) begin
      subCnt_q <= 6'h00;
    end else if (baudTick) begin
      subCnt_q <= subCnt_q + 6'h01; // RULE3
    end
  end

  // ---------------------------------------------------------------
  // Transmit sequencer
  // ---------------------------------------------------------------

  // Frame image, stop bit on top, start bit at the bottom, LSB first
  assign frameWord = txCtrl_q[`AST_TXCS_NINTH_EN]
    ? {1'b1, txCtrl_q[`AST_TXCS_NINTH_VALUE], holdBuf_q, 1'b0} // RULE19 RULE5
    : {2'b11, holdBuf_q, 1'b0}; // RULE1 RULE23
  assign frameBits = txCtrl_q[`AST_TXCS_NINTH_EN] ? `AST_FRAME_BITS_9 : `AST_FRAME_BITS_8;

  // Transfer at a generator tick when empty, or right as the stop bit ends
  assign loadNow = txActive && bufFull_q
    && ((shifterEmpty && baudTick)
      || (state_q == ast_pkg::AST_SHIFT && bitTick && bitsLeft_q == 4'd1)); // RULE8 RULE9 RULE17

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ast_pkg::AST_IDLE;
      shiftReg_q <= 11'h7ff;
      bitsLeft_q <= 4'h0;
    end else if (!txActive) begin
      state_q <= ast_pkg::AST_IDLE; // RULE18
      shiftReg_q <= 11'h7ff;
      bitsLeft_q <= 4'h0;
    end else if (!sleepMode) begin
      case (state_q)
        ast_pkg::AST_IDLE: begin
          if (loadNow) begin
            shiftReg_q <= frameWord; // RULE16 RULE17
            bitsLeft_q <= frameBits;
            state_q <= ast_pkg::AST_ARMED;
          end
        end
        ast_pkg::AST_ARMED: begin
          if (bitTick) begin
            state_q <= ast_pkg::AST_SHIFT; // RULE15
          end
        end
        ast_pkg::AST_SHIFT: begin
          if (bitTick) begin
            if (bitsLeft_q == 4'd1) begin
              if (loadNow) begin
                shiftReg_q <= frameWord; // RULE8
                bitsLeft_q <= frameBits;
              end else begin
                state_q <= ast_pkg::AST_IDLE;
                shiftReg_q <= 11'h7ff;
                bitsLeft_q <= 4'h0;
              end
            end else begin
              shiftReg_q <= {1'b1, shiftReg_q[10:1]}; // RULE23
              bitsLeft_q <= bitsLeft_q - 4'd1;
            end
          end
        end
        default: begin
          state_q <= ast_pkg::AST_IDLE;
        end
      endcase
    end
  end

  // Pin idles high while enabled, released when disabled
  assign txLinePinOut = (state_q == ast_pkg::AST_SHIFT) ? shiftReg_q[0] : 1'b1; // RULE23
  assign txLinePinOen = !txActive; // RULE18

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence armedStart;
    state_q == ast_pkg::AST_ARMED && bitTick && txActive;
  endsequence

  sequence startBitOut;
    state_q == ast_pkg::AST_SHIFT && txLinePinOut == 1'b0 && !txLinePinOen;
  endsequence

  a_start_bit_low: assert property (armedStart |=> startBitOut) // RULE1
    else $error("start bit not driven low after shift clock");

  a_stop_bit_high: assert property (
    state_q == ast_pkg::AST_SHIFT && bitsLeft_q == 4'd1 |-> txLinePinOut) // RULE1
    else $error("stop bit not high");

  a_bit_tick_spacing: assert property ( // RULE3
    baudTick |=> subCnt_q == $past(subCnt_q) + 6'h01)
    else $error("generator tick did not advance the bit phase");

  a_phase_hold: assert property (!baudTick |=> $stable(subCnt_q)) // RULE3 RULE6
    else $error("bit phase moved without a generator tick");

  a_divisor_reload: assert property (
    baudTick |=> baudCnt_q == $past(baudDivisor_q)) // RULE22
    else $error("baud counter not reloaded from divisor");

  a_sleep_freeze: assert property (
    sleepMode && txActive |=> $stable(state_q) && $stable(subCnt_q)) // RULE6
    else $error("activity while in sleep");

  a_buffer_write_flag: assert property (holdWrite |=> !bufEmptyFlag) // RULE10
    else $error("empty flag not cleared by buffer write");

  a_irq_gating: assert property (
    !irqEnablesA_q[`AST_IRQ_TX_BIT] |-> !txIrq) // RULE11
    else $error("interrupt without enable");

  a_abort_release: assert property ( // RULE18
    !txActive |-> txLinePinOen ##1 shifterEmpty)
    else $error("transmitter not released on disable");

  a_status_read: assert property (
    busAccess && !wb_we_i && regHit(wb_adr_i, `AST_IDX_TX_CTRL_STATUS)
    |=> wb_ack_o && wb_dat_o[1] == $past(shifterEmpty)) // RULE12
    else $error("shifter-empty bit misread");

  a_load_sets_flag: assert property (loadNow && !holdWrite |=> bufEmptyFlag) // RULE9
    else $error("transfer did not empty the buffer");

  a_ninth_bit: assert property (
    loadNow && txCtrl_q[6] && shifterEmpty |=> shiftReg_q[9] == $past(txCtrl_q[0])) // RULE19
    else $error("ninth bit not taken from bit zero");

  // End of a stop bit, with or without a byte waiting in the buffer
  sequence stopEndQueued;
    state_q == ast_pkg::AST_SHIFT && bitTick && bitsLeft_q == 4'h1 && bufFull_q && txActive;
  endsequence

  sequence stopEndEmpty;
    state_q == ast_pkg::AST_SHIFT && bitTick && bitsLeft_q == 4'h1 && !bufFull_q;
  endsequence

  a_back_to_back: assert property (stopEndQueued |=> startBitOut) // RULE8 RULE17
    else $error("queued byte did not start right after the stop bit");

  a_stop_to_idle: assert property (stopEndEmpty |=> shifterEmpty) // RULE8 RULE12
    else $error("shifter not empty after the last stop bit");

  a_bit_count: assert property ( // RULE1
    state_q == ast_pkg::AST_SHIFT && bitTick && bitsLeft_q != 4'h1 && txActive
    |=> bitsLeft_q == $past(bitsLeft_q) - 4'h1)
    else $error("bit count did not step once per bit time");

endmodule : ast_serial_tx
`default_nettype wire

// file: core/ast_serial_tx_rules_placeholder.sv
// Intentionally minimal helper-free file: no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: testbench/ast_rx_model.sv
// Remote serial receiver model that samples the transmit line in mid-bit
`timescale 1ns/1ps
`default_nettype none
module ast_rx_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic nine,
  input wire logic line,
  input wire logic [15:0] bitClks,
  output logic rxValid,
  output logic [8:0] rxData,
  output logic rxStopOk
);
  logic busy_q;
  logic [15:0] cnt_q;
  logic [3:0] idx_q;
  logic [8:0] sh_q;
  // Start detect, mid-bit sampling, stop check; a disable drops a half frame
  always_ff @(posedge clk) begin
    rxValid <= 1'b0;
    if (rst || !en) begin
      busy_q <= 1'b0;
    end else if (!busy_q) begin
      busy_q <= !line;
      cnt_q <= bitClks >> 1;
      idx_q <= 4'h0;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end else begin
      cnt_q <= bitClks - 16'h0001;
      idx_q <= idx_q + 4'h1;
      if (idx_q == 4'h0) begin
        busy_q <= !line;
      end else if (idx_q <= (nine ? 4'h9 : 4'h8)) begin
        sh_q[idx_q - 4'h1] <= line;
      end else begin
        rxValid <= 1'b1;
        rxStopOk <= line;
        rxData <= nine ? sh_q : {1'b0, sh_q[7:0]};
        busy_q <= 1'b0;
      end
    end
  end
endmodule : ast_rx_model
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking testbench for the serial transmitter
`timescale 1ns/1ps
`default_nettype none
`include "ast_defines.svh"
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sleepMode = 1'b0, rxEn = 1'b0, nine = 1'b0;
  logic b2b = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] lfsr = 8'h3E;
  logic [7:0] fmt = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, pinOut, pinOen, txIrq, line, rxValid, rxStopOk;
  logic [8:0] rxData;
  logic [15:0] bitClks = 16'h0040;
  int errors = 0, n_checks = 0, cycles = 0, lastValid = 0;
  logic [31:0] readQ[$];
  logic [9:0] frameQ[$];

  always #25 clk = ~clk;
  assign line = pinOen ? 1'b1 : pinOut; // Pull-up holds a released line high

  ast_serial_tx DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sleepMode(sleepMode), .txLinePinOut(pinOut), .txLinePinOen(pinOen), .txIrq(txIrq));
  ast_rx_model rxModel (.clk(clk), .rst(rst), .en(rxEn), .nine(nine), .line(line),
    .bitClks(bitClks), .rxValid(rxValid), .rxData(rxData), .rxStopOk(rxStopOk));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // Watch read answers, received frames and the cycle budget
  always @(posedge clk) begin
    cycles++;
    if (ack === 1'b1 && we === 1'b0) check(rdat, readQ.pop_front());
    if (rxValid === 1'b1) begin
      if (b2b && lastValid != 0) check(cycles - lastValid, 10 * bitClks);
      lastValid = cycles;
      check({rxStopOk, rxData}, frameQ.size() > 0 ? frameQ.pop_front() : 'x);
    end
    if (cycles == 60000) begin
      errors++;
      results();
    end
  end

  // One classic bus cycle, held until ack is sampled
  task automatic wbCycle(input logic [5:0] idx, input logic wr, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wbCycle

  task automatic wbRead(input logic [5:0] idx, input logic [31:0] exp);
    readQ.push_back(exp);
    wbCycle(idx, 1'b0, 8'h00);
  endtask : wbRead

  task automatic waitFor(input int what);
    int n;
    n = 0;
    while (n < 4000 && (what ? txIrq !== 1'b1 : frameQ.size() != 0)) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) begin
      errors++;
      $display("ERROR at %0t: wait limit reached", $time);
    end
    repeat (4) @(posedge clk);
  endtask : waitFor

  // Next value of the stimulus shift register
  function automatic logic [7:0] lfsrNext(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsrNext

  // Queue a byte and write it to the holding buffer
  task automatic sendByte(input logic ninth);
    lfsr = lfsrNext(lfsr);
    frameQ.push_back({1'b1, ninth, lfsr});
    wbCycle(`AST_IDX_TX_HOLDING_BUF, 1'b1, lfsr);
  endtask : sendByte

  task automatic burst(input int n);
    lastValid = 0;
    b2b = 1'b1;
    repeat (n) begin
      waitFor(1);
      sendByte(1'b0);
    end
    wbRead(`AST_IDX_TX_CTRL_STATUS, 32'h0000_0020);
    waitFor(0);
    b2b = 1'b0;
  endtask : burst

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wbRead(`AST_IDX_TX_CTRL_STATUS, 32'h0000_0002);
    wbRead(`AST_IDX_BAUD_DIVISOR, 32'h0000_0000);
    wbCycle(`AST_IDX_IRQ_FLAGS_A, 1'b1, 8'h00);
    wbRead(`AST_IDX_IRQ_FLAGS_A, 32'h0000_0002);
    wbCycle(`AST_IDX_TX_CTRL_STATUS, 1'b1, 8'h00);
    wbRead(`AST_IDX_TX_CTRL_STATUS, 32'h0000_0002);
    wbRead(6'h3F, 32'h0000_0000);
    $display("Test reset values done");
    wbCycle(`AST_IDX_BAUD_DIVISOR, 1'b1, 8'h00);
    wbCycle(`AST_IDX_RX_CTRL_STATUS, 1'b1, 8'h80);
    @(posedge clk);
    check(txIrq, 1'b0);
    wbCycle(`AST_IDX_IRQ_ENABLES_A, 1'b1, 8'h02);
    @(posedge clk);
    check(txIrq, 1'b1);
    rxEn <= 1'b1;
    sendByte(1'b0);
    @(posedge clk);
    check(txIrq, 1'b0);
    repeat (200) @(posedge clk);
    check(line, 1'b1);
    wbCycle(`AST_IDX_TX_CTRL_STATUS, 1'b1, 8'h20);
    waitFor(0);
    $display("Test write then enable done");
    burst(3);
    $display("Test back to back done");
    for (int m = 0; m < 3; m++) begin
      fmt = (m == 0) ? 8'h60 : (m == 1) ? 8'h61 : 8'h21;
      nine <= fmt[6];
      wbCycle(`AST_IDX_TX_CTRL_STATUS, 1'b1, fmt);
      sendByte(fmt[6] & fmt[0]);
      waitFor(0);
    end
    nine <= 1'b0;
    wbCycle(`AST_IDX_TX_CTRL_STATUS, 1'b1, 8'h20);
    $display("Test frame formats done");
    wbCycle(`AST_IDX_BAUD_DIVISOR, 1'b1, 8'h01);
    bitClks <= 16'h0080;
    burst(2);
    wbCycle(`AST_IDX_BAUD_DIVISOR, 1'b1, 8'h00);
    bitClks <= 16'h0040;
    $display("Test divisor done");
    sendByte(1'b0);
    void'(frameQ.pop_back());
    repeat (200) @(posedge clk);
    check(pinOen, 1'b0);
    rxEn <= 1'b0;
    wbCycle(`AST_IDX_TX_CTRL_STATUS, 1'b1, 8'h00);
    @(posedge clk);
    check(pinOen, 1'b1);
    wbRead(`AST_IDX_TX_CTRL_STATUS, 32'h0000_0002);
    wbCycle(`AST_IDX_TX_CTRL_STATUS, 1'b1, 8'h30);
    @(posedge clk);
    check(pinOen, 1'b1);
    wbCycle(`AST_IDX_TX_CTRL_STATUS, 1'b1, 8'h20);
    rxEn <= 1'b1;
    $display("Test abort and mode done");
    sleepMode <= 1'b1;
    sendByte(1'b0);
    repeat (300) @(posedge clk);
    check(txIrq, 1'b0);
    check(line, 1'b1);
    wbRead(`AST_IDX_TX_CTRL_STATUS, 32'h0000_0022);
    wbRead(`AST_IDX_TX_HOLDING_BUF, {24'h00_0000, lfsr});
    sleepMode <= 1'b0;
    waitFor(0);
    $display("Test sleep done");
    results();
  end
endmodule : testbench
`default_nettype wire
